// *** logic/csu_cfg.svh ***
// register offsets, field reset values and timing counts of the clock unit
`ifndef CSU_CFG_SVH
`define CSU_CFG_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CSU_OFF_CTRL1 8'h00
`define CSU_OFF_CTRL2 8'h04
`define CSU_OFF_TRIM 8'h08
`define CSU_OFF_FINE_TRIM_BIT 8'h0c
`define CSU_OFF_STATUS 8'h10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CSU_BUS_DIVIDER_FIELD_RST 2'h1
`define CSU_INTERNAL_REF_SELECT_RST 1'b1
`define CSU_TRIM_POR 8'h80
`define CSU_FINE_TRIM_BIT_POR 1'b0

// ------------------------------------------------------------
// bus answers and timing
// ------------------------------------------------------------
`define CSU_RESP_OKAY 2'h0
`define CSU_RESP_SLVERR 2'h2
`define CSU_CLK_NS 8
`define CSU_MISS_NS 10000
`define CSU_MISS_CYC (`CSU_MISS_NS / `CSU_CLK_NS)
`define CSU_NEW_EDGES 4
`define CSU_IREF_BASE 16

`endif

// *** logic/csu_pkg.sv ***
// types shared by the clock source unit and its bench
package csu_pkg;

   // ------------------------------------------------------------
   // clock source codes and switch states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_FLL = 2'b00,
      SRC_IREF = 2'b01,
      SRC_EREF = 2'b10,
      SRC_RSV = 2'b11
   } csu_src_t;

   typedef enum logic {
      SW_IDLE = 1'b0,
      SW_WAIT = 1'b1
   } csu_sw_t;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic sel_out;
      logic bus;
      logic iref;
      logic eref;
      logic fll_ref;
   } csu_clock_source_select_t;

   typedef struct packed {
      logic [7:0] coarse;
      logic fine;
   } csu_trim_t;

   typedef struct packed {
      csu_src_t clock_source_select;
      logic [2:0] reference_divider;
      logic internal_ref_select;
      logic internal_ref_output_enable;
      logic internal_ref_stop_enable;
      logic [1:0] bus_divider_field;
      logic lp;
      logic external_ref_output_enable;
      csu_src_t active;
      csu_src_t pend;
      csu_sw_t sw;
      logic [2:0] edges;
      logic [11:0] miss;
      logic [9:0] iref_cnt;
      logic iref_lvl;
      logic prv_fll;
      logic prv_ext;
      logic [2:0] div_cnt;
      csu_clock_source_select_t clk;
      logic fll_en;
      logic [2:0] fll_reference_divider;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [7:0] wdata;
      logic wstb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } csu_st_t;

endpackage

// *** logic/csu_top.sv ***
// clock source unit: source select, bus divider, trim and reference outputs
`timescale 1ns/10ps
`include "csu_cfg.svh"

// Notes on behaviour
// - system clock is FLL, internal or external
// - selected source passes bus divider; bus halves
// - warm reset (reset_n_i) gives FLL internal, divider 1:2
// - power-on loads coarse trim 0x80, fine 0
// - other resets keep both trim values
// - switch completes after several new clock cycles
// - dead new source keeps previous clock active
// - bus divider writes take effect at once
// - low power disables FLL when unselected
// - low power cleared keeps FLL running
// - internal enable drives internal reference output
// - larger coarse trim gives longer reference period
// - trim reaches output only in internal modes
// - both enables keep internal reference in stop
// - external enable drives external reference output
// - internal select keeps external reference off FLL
// - external reference 100 kHz to 5 MHz accepted
module csu_top #(
   parameter int MISS_CYC = `CSU_MISS_CYC,
   parameter int NEW_EDGES = `CSU_NEW_EDGES,
   parameter int IREF_BASE = `CSU_IREF_BASE
) (
   // clock and resets
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic por_n_i,
   // chip state and clock sources
   input wire logic stop_i,
   input wire logic fll_clk_i,
   input wire logic ext_ref_clk_i,
   // axi4-lite write channels
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // axi4-lite read channels
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // clock outputs and FLL control
   output csu_pkg::csu_clock_source_select_t clk_o,
   output logic fll_en_o,
   output logic [2:0] fll_reference_divider_o
);
   import csu_pkg::*;

   csu_st_t s;
   csu_st_t n;
   csu_trim_t t;
   csu_trim_t nt;
   logic fll_rise;
   logic ext_rise;
   logic iref_run;
   logic iref_rise;
   logic [9:0] iref_half;
   logic sel_lvl;
   logic sel_rise;
   logic pend_rise;
   logic [7:0] wa;
   logic [7:0] ra;

   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   // pick one of three levels by source code; reserved gives low
   function automatic logic src_pick(input csu_src_t src, input logic f,
                                     input logic i, input logic e);
      case (src)
         SRC_FLL: src_pick = f;
         SRC_IREF: src_pick = i;
         SRC_EREF: src_pick = e;
         default: src_pick = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // source sampling
   // ------------------------------------------------------------
   // inputs are synchronous; external reference up to 5 MHz is
   // well oversampled at 125 MHz
   assign fll_rise = fll_clk_i & ~s.prv_fll;
   assign ext_rise = ext_ref_clk_i & ~s.prv_ext;
   // internal reference runs when used or when kept for stop
   assign iref_run = (s.internal_ref_output_enable & (~stop_i | s.internal_ref_stop_enable)) |
                     (~stop_i & (s.internal_ref_select | s.active == SRC_IREF |
                                 s.clock_source_select == SRC_IREF));
   assign iref_rise = iref_run & (s.iref_cnt == 10'h000) & ~s.iref_lvl;
   // half period grows with trim, fine bit adds half a step
   assign iref_half = 10'(IREF_BASE) + {1'b0, t.coarse, t.fine};
   assign sel_lvl = src_pick(s.active, fll_clk_i, s.iref_lvl,
                             ext_ref_clk_i);
   assign sel_rise = src_pick(s.active, fll_rise, iref_rise, ext_rise);
   assign pend_rise = src_pick(s.pend, fll_rise, iref_rise, ext_rise);
   assign wa = {s.waddr[7:2], 2'h0};
   assign ra = {araddr_i[7:2], 2'h0};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      n = s;
      nt = t;
      n.prv_fll = fll_clk_i;
      n.prv_ext = ext_ref_clk_i;

      // internal reference oscillator from a reloading counter
      if (iref_run) begin
         if (s.iref_cnt == 10'h000) begin
            n.iref_cnt = iref_half;
            n.iref_lvl = ~s.iref_lvl;
         end else begin
            n.iref_cnt = s.iref_cnt - 10'h001;
         end
      end

      // source switch: wait for edges of the new clock, give up
      // if it stays silent so the old one keeps running
      case (s.sw)
         SW_IDLE: begin
            if (s.clock_source_select != s.active && s.clock_source_select != SRC_RSV) begin
               n.sw = SW_WAIT;
               n.pend = s.clock_source_select;
               n.edges = 3'h0;
               n.miss = 12'h000;
            end
         end
         SW_WAIT: begin
            if (s.clock_source_select == s.active || s.clock_source_select == SRC_RSV) begin
               n.sw = SW_IDLE;
            end else if (s.clock_source_select != s.pend) begin
               n.pend = s.clock_source_select;
               n.edges = 3'h0;
               n.miss = 12'h000;
            end else if (pend_rise) begin
               n.miss = 12'h000;
               if (s.edges == 3'(NEW_EDGES - 1)) begin
                  n.active = s.pend;
                  n.sw = SW_IDLE;
               end else begin
                  n.edges = s.edges + 3'h1;
               end
            end else if (s.miss == 12'(MISS_CYC - 1)) begin
               n.sw = SW_IDLE;
            end else begin
               n.miss = s.miss + 12'h001;
            end
         end
         default: n.sw = SW_IDLE;
      endcase

      // bus divider counts rising edges of the active source; the
      // code is read live, so a new ratio applies at once
      if (sel_rise) begin
         n.div_cnt = s.div_cnt + 3'h1;
      end
      case (s.bus_divider_field)
         2'h0: n.clk.sel_out = sel_lvl;
         2'h1: n.clk.sel_out = n.div_cnt[0];
         2'h2: n.clk.sel_out = n.div_cnt[1];
         default: n.clk.sel_out = n.div_cnt[2];
      endcase
      // a ratio change may shorten one output phase; no glitch filter
      if (n.clk.sel_out & ~s.clk.sel_out) begin
         n.clk.bus = ~s.clk.bus;
      end

      // gated reference outputs and FLL reference path
      n.clk.iref = s.iref_lvl & s.internal_ref_output_enable &
                   (~stop_i | s.internal_ref_stop_enable);
      n.clk.eref = ext_ref_clk_i & s.external_ref_output_enable;
      // trim only reaches the FLL through the internal reference
      n.clk.fll_ref = s.internal_ref_select ? s.iref_lvl : ext_ref_clk_i;
      n.fll_en = ~(s.lp & s.active != SRC_FLL &
                   s.clock_source_select != SRC_FLL);
      n.fll_reference_divider = s.reference_divider;

      // write address and data are taken in either order
      if (awvalid_i & s.awready) begin
         n.aw_got = 1'b1;
         n.waddr = awaddr_i;
      end
      if (wvalid_i & s.wready) begin
         n.w_got = 1'b1;
         n.wdata = wdata_i[7:0];
         n.wstb = wstrb_i[0];
      end
      if (s.aw_got & s.w_got) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `CSU_RESP_OKAY;
         case (wa)
            `CSU_OFF_CTRL1: begin
               if (s.wstb) begin
                  n.clock_source_select = csu_src_t'(s.wdata[7:6]);
                  n.reference_divider = s.wdata[5:3];
                  n.internal_ref_select = s.wdata[2];
                  n.internal_ref_output_enable = s.wdata[1];
                  n.internal_ref_stop_enable = s.wdata[0];
               end
            end
            `CSU_OFF_CTRL2: begin
               if (s.wstb) begin
                  n.bus_divider_field = s.wdata[7:6];
                  n.lp = s.wdata[3];
                  n.external_ref_output_enable = s.wdata[1];
               end
            end
            `CSU_OFF_TRIM: begin
               if (s.wstb) begin
                  nt.coarse = s.wdata;
               end
            end
            `CSU_OFF_FINE_TRIM_BIT: begin
               if (s.wstb) begin
                  nt.fine = s.wdata[0];
               end
            end
            `CSU_OFF_STATUS: n.bresp = `CSU_RESP_OKAY;
            default: n.bresp = `CSU_RESP_SLVERR;
         endcase
      end else if (s.bvalid & bready_i) begin
         n.bvalid = 1'b0;
      end
      n.awready = ~n.aw_got & ~n.bvalid;
      n.wready = ~n.w_got & ~n.bvalid;

      // read answers one cycle after the address is taken
      if (arvalid_i & s.arready) begin
         n.rvalid = 1'b1;
         n.rresp = `CSU_RESP_OKAY;
         case (ra)
            `CSU_OFF_CTRL1: n.rdata = {s.clock_source_select, s.reference_divider, s.internal_ref_select,
                                       s.internal_ref_output_enable, s.internal_ref_stop_enable};
            `CSU_OFF_CTRL2: n.rdata = {s.bus_divider_field, 2'h0, s.lp, 1'b0,
                                       s.external_ref_output_enable, 1'b0};
            `CSU_OFF_TRIM: n.rdata = t.coarse;
            `CSU_OFF_FINE_TRIM_BIT: n.rdata = {7'h00, t.fine};
            `CSU_OFF_STATUS: n.rdata = {4'h0, s.active, s.sw, s.fll_en};
            default: begin
               n.rdata = 8'h00;
               n.rresp = `CSU_RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid & rready_i) begin
         n.rvalid = 1'b0;
      end
      n.arready = ~n.rvalid;
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   // reset_n_i (warm reset) returns to FLL engaged internal, divide by two; por_n_i alone leaves this state
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= '0;
         s.internal_ref_select <= `CSU_INTERNAL_REF_SELECT_RST;
         s.bus_divider_field <= `CSU_BUS_DIVIDER_FIELD_RST;
         s.fll_en <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // trim sits on power-on reset only so warm resets keep it
   always_ff @(posedge mclk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         t <= {`CSU_TRIM_POR, `CSU_FINE_TRIM_BIT_POR};
      end else begin
         t <= nt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign awready_o = s.awready;
   assign wready_o = s.wready;
   assign bvalid_o = s.bvalid;
   assign bresp_o = s.bresp;
   assign arready_o = s.arready;
   assign rvalid_o = s.rvalid;
   assign rresp_o = s.rresp;
   assign rdata_o = {24'h000000, s.rdata};
   assign clk_o = s.clk;
   assign fll_en_o = s.fll_en;
   assign fll_reference_divider_o = s.fll_reference_divider;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence seq_last_edge;
      s.sw == SW_WAIT && pend_rise && s.clock_source_select == s.pend &&
      s.edges == 3'(NEW_EDGES - 1);
   endsequence
   sequence seq_gave_up;
      s.sw == SW_WAIT && !pend_rise && s.clock_source_select == s.pend &&
      s.miss == 12'(MISS_CYC - 1);
   endsequence

   a_reset_mode: assert property ($rose(reset_n_i) |->
      s.bus_divider_field == 2'h1 && s.clock_source_select == SRC_FLL && s.internal_ref_select)
      else $error("reset did not give internal FLL divide by two");
   a_trim_por: assert property (@(posedge mclk_i)
      disable iff (!por_n_i) $rose(por_n_i) |->
      t.coarse == `CSU_TRIM_POR && t.fine == `CSU_FINE_TRIM_BIT_POR)
      else $error("power-on trim value wrong");
   a_trim_warm: assert property (@(posedge mclk_i)
      disable iff (!por_n_i) !reset_n_i ##1 !reset_n_i |->
      $stable(t))
      else $error("trim changed across warm reset");
   a_switch_done: assert property ($changed(s.active) |->
      $past(s.sw == SW_WAIT && pend_rise &&
            s.edges == 3'(NEW_EDGES - 1)))
      else $error("source switched before enough new edges");
   a_switch_take: assert property (seq_last_edge |=>
      s.active == $past(s.pend) && s.sw == SW_IDLE)
      else $error("source switch did not complete");
   a_switch_keep: assert property (seq_gave_up |=>
      s.active == $past(s.active) && s.sw == SW_IDLE)
      else $error("dead source replaced the running clock");
   a_bus_divider_field_now: assert property (s.bus_divider_field == 2'h0 |=>
      clk_o.sel_out == $past(sel_lvl))
      else $error("divide by one not applied at once");
   a_bus_half: assert property ($rose(clk_o.sel_out) |->
      $changed(clk_o.bus))
      else $error("bus clock not at half output rate");
   a_fll_off: assert property (s.lp && s.active != SRC_FLL &&
      s.clock_source_select != SRC_FLL |=> !fll_en_o)
      else $error("FLL left on in low power");
   a_fll_on: assert property (!s.lp |=> fll_en_o)
      else $error("FLL stopped with low power clear");
   a_iref_gate: assert property (!s.internal_ref_output_enable ||
      (stop_i && !s.internal_ref_stop_enable) |=> !clk_o.iref)
      else $error("internal reference output not gated");
   a_eref_gate: assert property (s.external_ref_output_enable ##1 s.external_ref_output_enable |->
      clk_o.eref == $past(ext_ref_clk_i))
      else $error("external reference output wrong");
   a_fll_ref: assert property (s.internal_ref_select |=>
      clk_o.fll_ref == $past(s.iref_lvl))
      else $error("external reference fed to FLL");
   a_trim_len: assert property (iref_run && s.iref_cnt == 10'h000
      && !(reset_n_i && $fell(por_n_i)) |=> s.iref_cnt == $past(iref_half))
      else $error("internal reference period ignores trim");
   a_no_rsv: assert property (s.active != SRC_RSV)
      else $error("reserved source became active");

endmodule

// *** sim/csu_osc_model.sv ***
// oscillator and FLL stand-in that feeds the clock unit's source inputs
`timescale 1ns/10ps
module csu_osc_model #(
   parameter int EXT_HALF = 13, // about 4.8 MHz, inside the accepted band
   parameter int FLL_HALF = 2
) (
   // clock
   input wire logic mclk_i,
   // controls
   input wire logic fll_en_i,
   input wire logic ext_run_i,
   // source clocks
   output logic fll_clk_o,
   output logic ext_ref_clk_o
);
   int fll_cnt = 0;
   int ext_cnt = 0;
   logic fll_q = 1'b0;
   logic ext_q = 1'b0;

   // ------------------------------------------------------------
   // source generators
   // ------------------------------------------------------------
   // one process owns each level; the ports only mirror it
   assign fll_clk_o = fll_q;
   assign ext_ref_clk_o = ext_q;

   // a halted source parks low, as a stopped oscillator would
   always @(posedge mclk_i) begin
      fll_cnt <= (fll_cnt + 1) % FLL_HALF;
      ext_cnt <= (ext_cnt + 1) % EXT_HALF;
      if (!fll_en_i)
         fll_q <= 1'b0;
      else if (fll_cnt == 0)
         fll_q <= ~fll_q;
      if (!ext_run_i)
         ext_q <= 1'b0;
      else if (ext_cnt == 0)
         ext_q <= ~ext_q;
   end
endmodule

// *** sim/internal_clock_source_select_test.sv ***
// self-checking bench of the clock source unit
`timescale 1ns/10ps
module internal_clock_source_select_test;
   import csu_pkg::*;
   logic mclk_i = 1'b0, reset_n_i = 1'b0, por_n_i = 1'b0, stop_i = 1'b0;
   logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic [3:0] wstrb_i = 4'h0;
   logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
   logic arvalid_i = 1'b0, rready_i = 1'b0;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, fll_en_o;
   logic [1:0] bresp_o, rresp_o, resp;
   logic [31:0] rdata_o, rd;
   logic [2:0] fll_reference_divider_o;
   csu_clock_source_select_t clk_o;
   logic fll_clk, ext_clk, ext_run = 1'b0;
   int mismatches = 0;
   int cmp_count = 0;
   int cnt[5];
   int mdl[5] = '{4, 64, 128, 0, 0};
   int msk[5] = '{255, 202, 255, 1, 0};
   logic [31:0] seed = 32'h00000026;

   always #4 mclk_i = ~mclk_i;

   csu_top #(.MISS_CYC(50), .NEW_EDGES(4), .IREF_BASE(2)) u_csu_top (
      .mclk_i, .reset_n_i, .por_n_i, .stop_i, .fll_clk_i(fll_clk),
      .ext_ref_clk_i(ext_clk), .awaddr_i, .awvalid_i, .awready_o,
      .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
      .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o,
      .rvalid_o, .rready_i, .clk_o, .fll_en_o, .fll_reference_divider_o);

   csu_osc_model u_csu_osc_model (.mclk_i, .fll_en_i(fll_en_o),
      .ext_run_i(ext_run), .fll_clk_o(fll_clk), .ext_ref_clk_o(ext_clk));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // clock counts drift by one with phase, so allow a step either way
   task automatic near(input string nm, input int e, input int g);
      cmp_count++;
      if (g < e - 1 || g > e + 1) begin
         mismatches++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // bus master
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr_i <= a;
      wdata_i <= {24'h000000, d};
      wstrb_i <= 4'hf;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (awvalid_i && awready_o === 1'b1)
            awvalid_i <= 1'b0;
         if (wvalid_i && wready_o === 1'b1)
            wvalid_i <= 1'b0;
         if (bready_i && bvalid_o === 1'b1) begin
            resp = bresp_o;
            bready_i <= 1'b0;
         end
      end while (bready_i);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (arvalid_i && arready_o === 1'b1)
            arvalid_i <= 1'b0;
         if (rready_i && rvalid_o === 1'b1) begin
            rd = rdata_o;
            resp = rresp_o;
            rready_i <= 1'b0;
         end
      end while (rready_i);
   endtask

   // writes keep the bench's register image in step
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      wr(a, d);
      mdl[a[4:2]] = d & msk[a[4:2]];
      chk("bresp", 0, resp);
   endtask

   task automatic chkreg(input string nm, input logic [7:0] a, input int e);
      rd_reg(a);
      chk(nm, e, rd);
      chk("rresp", 0, resp);
   endtask

   task automatic waitsrc(input logic [1:0] s);
      int n;
      n = 0;
      do begin
         rd_reg(8'h10);
         n++;
      end while (rd[3:2] !== s && n < 60);
      chk("active source", s, rd[3:2]);
   endtask

   // rises of each clock output over a window, read at each edge so
   // that inputs driven afterwards still change on the rising edge
   task automatic count(input int cyc);
      csu_clock_source_select_t p;
      p = clk_o;
      cnt = '{default: 0};
      repeat (cyc) begin
         @(posedge mclk_i);
         for (int i = 0; i < 5; i++)
            if (clk_o[i] === 1'b1 && p[i] === 1'b0)
               cnt[i]++;
         p = clk_o;
      end
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #200000;
      mismatches++;
      results();
   end

   initial begin
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      por_n_i <= 1'b1;
      @(posedge mclk_i);
      chkreg("ctrl1", 8'h00, mdl[0]);
      chkreg("ctrl2", 8'h04, mdl[1]);
      chkreg("trim", 8'h08, mdl[2]);
      chkreg("fine_trim_bit", 8'h0c, mdl[3]);
      chkreg("status", 8'h10, 1);
      count(200);
      near("reset sel", 25, cnt[4]);
      near("reset bus", 12, cnt[3]);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         put(8'h08, xs());
         put(8'h0c, xs());
         chkreg("trim", 8'h08, mdl[2]);
         chkreg("fine_trim_bit", 8'h0c, mdl[3]);
      end
      put(8'h10, 8'hff);
      chkreg("status ro", 8'h10, 1);
      wr(8'h20, 8'h55);
      chk("wr unmapped", 2, resp);
      rd_reg(8'h24);
      chk("rd unmapped", 2, resp);
      chk("rd unmapped data", 0, rd);
      // warm reset must leave trim alone
      reset_n_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      chkreg("trim kept", 8'h08, mdl[2]);
      chkreg("fine_trim_bit kept", 8'h0c, mdl[3]);
      chkreg("ctrl2 warm", 8'h04, 64);
      $display("test registers done");
      put(8'h08, 8'h02);
      put(8'h0c, 8'h00);
      put(8'h00, 8'h07);
      // a long half period from the random trim only reloads at zero
      repeat (520) @(posedge mclk_i);
      stop_i <= 1'b1;
      count(200);
      near("iref in stop", 14, cnt[2]);
      put(8'h00, 8'h06);
      count(200);
      chk("iref stop gated", 0, cnt[2]);
      stop_i <= 1'b0;
      count(400);
      near("iref out", 28, cnt[2]);
      near("fll ref int", 28, cnt[0]);
      put(8'h08, 8'h08);
      count(400);
      near("iref slow", 10, cnt[2]);
      $display("test internal ref done");
      put(8'h08, 8'h02);
      put(8'h00, 8'h46);
      waitsrc(2'b01);
      for (int b = 0; b < 4; b++) begin
         put(8'h04, 8'(b << 6));
         count(560);
         near("sel div", 40 >> b, cnt[4]);
         near("bus half", 20 >> b, cnt[3]);
      end
      $display("test divider done");
      put(8'h00, 8'h90);
      repeat (120) @(posedge mclk_i);
      rd_reg(8'h10);
      chk("dead source", 1, rd[3:2]);
      ext_run <= 1'b1;
      rd_reg(8'h10);
      chk("switch not instant", 1, rd[3:2]);
      chk("fll reference_divider", 2, fll_reference_divider_o);
      waitsrc(2'b10);
      put(8'h04, 8'h0a);
      put(8'h08, 8'h40);
      count(520);
      near("eref out", 20, cnt[1]);
      near("sel ext", 20, cnt[4]);
      near("fll ref ext", 20, cnt[0]);
      chk("fll off", 0, fll_en_o);
      put(8'h04, 8'h02);
      repeat (2) @(posedge mclk_i);
      chk("fll on", 1, fll_en_o);
      put(8'h00, 8'h04);
      waitsrc(2'b00);
      count(200);
      near("sel fll", 50, cnt[4]);
      // reserved select is stored but never taken
      put(8'h00, 8'hc4);
      repeat (60) @(posedge mclk_i);
      chkreg("ctrl1 rsv", 8'h00, mdl[0]);
      waitsrc(2'b00);
      $display("test source switch done");
      results();
   end
endmodule
